// ---- rcs_pkg.sv ----
// Purpose: shared constants and types for the reset and clock start-up block
// Assumes: one 10 MHz system clock, synchronous active-high reset
// Notes: oscillator figures are nominal and only describe the sources
package rcs_pkg;
  localparam int FAST_INT_OSC_HZ = 16000000;
  localparam int SLOW_INT_OSC_HZ = 38000;
  localparam int FAST_EXT_OSC_MAX_HZ = 16000000;
  localparam int SLOW_EXT_OSC_HZ = 32768;
  localparam int CORE_CLK_HZ = 2000000;
  localparam logic [3:0] STARTUP_DIV = 4'h8;
  localparam logic [2:0] DIV_LAST = 3'h7;
  localparam logic [1:0] RST_HOLD_CYCLES = 2'h3;
  localparam int CLK_HZ = 10000000;
  localparam int CLK_PERIOD_NS = 100;

  typedef enum logic [1:0] {
    RCS_CLK_FAST_INT = 2'h0,
    RCS_CLK_SLOW_INT = 2'h1,
    RCS_CLK_FAST_EXT = 2'h2,
    RCS_CLK_SLOW_EXT = 2'h3
  } rcs_clk_src_t;

  typedef enum logic [1:0] {
    RCS_ST_RESET = 2'b00,
    RCS_ST_RELEASE = 2'b01,
    RCS_ST_RUN = 2'b11
  } rcs_state_t;

  typedef struct packed {
    logic watchdogIndep;
    logic watchdogWindow;
    logic softwareReq;
    logic debugReq;
    logic illegalOp;
  } rcs_rst_src_t;

  typedef struct packed {
    logic fastExtEnable;
    logic slowExtEnable;
    logic slowExtBypass;
  } rcs_osc_cfg_t;
endpackage : rcs_pkg

// ---- rcs_reset_clock_startup.sv ----
// Purpose: reset gathering, start-up clock selection and oscillator pin sharing
// Assumes: all inputs synchronous to clk; supply detector gives level flags
// Notes: core clock enable is a strobe, not a generated clock
//
// Function
// RL1: after any reset the core runs from the fast internal oscillator divided by eight, 2 MHz.
// RL2: two internal sources exist, a 16 MHz fast and a roughly 38 kHz slow oscillator.
// RL3: no external reset pin exists, the first reset comes from power-on detection only.
// RL4: reset is held during power-up until the supply reaches the brown-out monitoring level.
// RL5: independent watchdog expiry or window watchdog fault gives a full reset.
// RL6: software can request a full device reset.
// RL7: a debug probe on the single-wire line can request a full reset through the debug module.
// RL8: a fetched byte that is neither a valid opcode nor a prefix causes reset.
// RL9: any internal reset aborts a running debug-line session, and the probe reconnects.
// RL10: the probe must attach while code runs, since no reset pin allows attach under reset.
// RL11: with a bootloader present, an empty program memory makes the device run the bootloader.
// RL12: one variant accepts a fast external clock up to 16 MHz and a 32.768 kHz slow external clock.
// RL13: both external clocks may run together only with the slow one in bypass from its input pin.
// RL14: an unused external oscillator frees its pins as general-purpose I/O.
// RL15: reset is also raised when the supply drops below the brown-out level, with hysteresis.
// RL16: all sources merge into one system reset released synchronously once all have deasserted.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_clock_startup
  import rcs_pkg::*;
#(
  parameter bit HAS_EXT_OSC = 1'b1,
  parameter bit HAS_BOOTLOADER = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic supplyAboveRise,
  input wire logic supplyAboveFall,
  input wire rcs_rst_src_t rstReq,
  input wire logic progMemEmpty,
  input wire logic debugSessionActive,
  input wire logic clkSwitchReq,
  input wire rcs_clk_src_t clkSwitchSel,
  input wire rcs_osc_cfg_t oscCfg,
  output logic sysRst,
  output logic coreClkEn,
  output rcs_clk_src_t coreClkSel,
  output logic fastIntOscOn,
  output logic slowIntOscOn,
  output logic fastExtOscOn,
  output logic slowExtOscOn,
  output logic fastOscPinIsGpio,
  output logic slowOscInPinIsGpio,
  output logic slowOscOutPinIsGpio,
  output logic bootFromLoader,
  output logic debugAbort
);
  rcs_state_t state_q, state_d;
  logic supplyOk_q, supplyOk_d;
  logic [1:0] hold_q, hold_d;
  logic [2:0] div_q, div_d;
  logic coreClkEn_q, coreClkEn_d;
  rcs_clk_src_t sel_q, sel_d;
  logic boot_q, boot_d;
  logic abort_q, abort_d;
  logic fastExt_q, fastExt_d, slowExt_q, slowExt_d;
  logic anyReq;

  // hysteresis: rise above the upper level to leave reset, fall below the lower to enter
  always_comb begin
    supplyOk_d = supplyOk_q;
    if (!supplyAboveFall) begin
      supplyOk_d = 1'b0; // [RL15]
    end else if (supplyAboveRise) begin
      supplyOk_d = 1'b1; // [RL4]
    end
  end

  // internal sources only; there is no pin to merge in [RL3]
  assign anyReq = !supplyOk_q || (|rstReq); // [RL5] [RL6] [RL7] [RL8]

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    case (state_q)
      RCS_ST_RESET: begin
        hold_d = '0;
        if (!anyReq) begin
          state_d = RCS_ST_RELEASE;
        end
      end
      RCS_ST_RELEASE: begin
        // a few quiet cycles filter a source that bounces on release [RL16]
        if (anyReq) begin
          state_d = RCS_ST_RESET;
        end else if (hold_q == RST_HOLD_CYCLES) begin
          state_d = RCS_ST_RUN;
        end else begin
          hold_d = hold_q + 2'h1;
        end
      end
      RCS_ST_RUN: begin
        if (anyReq) begin
          state_d = RCS_ST_RESET;
        end
      end
      default: begin
        state_d = RCS_ST_RESET;
      end
    endcase
  end

  always_comb begin
    sel_d = sel_q;
    div_d = div_q + 3'h1;
    coreClkEn_d = 1'b0;
    boot_d = boot_q;
    fastExt_d = fastExt_q;
    slowExt_d = slowExt_q;
    abort_d = 1'b0;
    if (state_q != RCS_ST_RUN) begin
      sel_d = RCS_CLK_FAST_INT; // [RL1]
      div_d = '0;
      fastExt_d = 1'b0;
      slowExt_d = 1'b0;
      abort_d = debugSessionActive; // [RL9]
      boot_d = HAS_BOOTLOADER && progMemEmpty; // [RL11]
    end else begin
      // one strobe every eight enabled clk cycles, whichever source is selected [RL1]
      coreClkEn_d = (div_q == DIV_LAST);
      if (HAS_EXT_OSC) begin
        fastExt_d = oscCfg.fastExtEnable; // [RL12]
        // shared pin: slow crystal mode loses to the fast external oscillator [RL13]
        slowExt_d = oscCfg.slowExtEnable && (!oscCfg.fastExtEnable || oscCfg.slowExtBypass);
      end
      if (clkSwitchReq) begin
        case (clkSwitchSel)
          RCS_CLK_FAST_EXT: if (fastExt_q) sel_d = clkSwitchSel;
          RCS_CLK_SLOW_EXT: if (slowExt_q) sel_d = clkSwitchSel;
          default: sel_d = clkSwitchSel; // [RL2]
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RCS_ST_RESET;
      supplyOk_q <= 1'b0;
      hold_q <= '0;
      div_q <= '0;
      coreClkEn_q <= 1'b0;
      sel_q <= RCS_CLK_FAST_INT;
      boot_q <= 1'b0;
      abort_q <= 1'b0;
      fastExt_q <= 1'b0;
      slowExt_q <= 1'b0;
      sysRst <= 1'b1;
      fastIntOscOn <= 1'b1;
      slowIntOscOn <= 1'b1;
      fastOscPinIsGpio <= 1'b1;
      slowOscInPinIsGpio <= 1'b1;
      slowOscOutPinIsGpio <= 1'b1;
    end else if (clkEn) begin
      state_q <= state_d;
      supplyOk_q <= supplyOk_d;
      hold_q <= hold_d;
      div_q <= div_d;
      coreClkEn_q <= coreClkEn_d;
      sel_q <= sel_d;
      boot_q <= boot_d;
      abort_q <= abort_d;
      fastExt_q <= fastExt_d;
      slowExt_q <= slowExt_d;
      sysRst <= (state_d != RCS_ST_RUN); // [RL16]
      fastIntOscOn <= 1'b1; // [RL2]
      slowIntOscOn <= 1'b1; // [RL2]
      // pins return to I/O when their oscillator is idle [RL14]
      fastOscPinIsGpio <= !fastExt_d && !(slowExt_d && !oscCfg.slowExtBypass);
      slowOscInPinIsGpio <= !slowExt_d;
      slowOscOutPinIsGpio <= !fastExt_d && !(slowExt_d && !oscCfg.slowExtBypass);
    end
  end

  assign coreClkEn = coreClkEn_q;
  assign coreClkSel = sel_q;
  assign fastExtOscOn = fastExt_q;
  assign slowExtOscOn = slowExt_q;
  assign bootFromLoader = boot_q;
  assign debugAbort = abort_q;

  property p_dropReset;
    @(posedge clk) disable iff (rst) (clkEn && !supplyAboveFall) ##1 clkEn |=> sysRst;
  endproperty
  a_dropReset: assert property (p_dropReset) else $error("supply drop did not reset"); // [RL15]

  property p_reqReset;
    @(posedge clk) disable iff (rst) (clkEn && state_q == RCS_ST_RUN && |rstReq) |=> (!clkEn || sysRst);
  endproperty
  a_reqReset: assert property (p_reqReset) else $error("reset request ignored"); // [RL5]

  property p_debugReq;
    @(posedge clk) disable iff (rst) (clkEn && rstReq.debugReq) |=> sysRst;
  endproperty
  a_debugReq: assert property (p_debugReq) else $error("debug reset ignored"); // [RL7]

  property p_startClk;
    @(posedge clk) disable iff (rst) (clkEn && state_q == RCS_ST_RESET) |=> coreClkSel == RCS_CLK_FAST_INT;
  endproperty
  a_startClk: assert property (p_startClk) else $error("start clock not fast internal"); // [RL1]

  sequence s_quiet;
    (clkEn && !anyReq && state_q == RCS_ST_RESET) ##1 (clkEn && !anyReq) [*4];
  endsequence
  property p_release;
    @(posedge clk) disable iff (rst) s_quiet |=> !sysRst;
  endproperty
  a_release: assert property (p_release) else $error("reset not released"); // [RL16]

  property p_noEarly;
    @(posedge clk) disable iff (rst) (state_q == RCS_ST_RESET) |=> sysRst;
  endproperty
  a_noEarly: assert property (p_noEarly) else $error("reset released too early"); // [RL4]

  property p_abort;
    @(posedge clk) disable iff (rst) (clkEn && state_q != RCS_ST_RUN && debugSessionActive) |=> debugAbort;
  endproperty
  a_abort: assert property (p_abort) else $error("debug session not aborted"); // [RL9]

  property p_shared;
    @(posedge clk) disable iff (rst) (fastExtOscOn && slowExtOscOn) |-> $past(oscCfg.slowExtBypass);
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin conflict"); // [RL13]

  property p_divide;
    @(posedge clk) disable iff (rst) (clkEn && coreClkEn && state_q == RCS_ST_RUN) |=> !coreClkEn;
  endproperty
  a_divide: assert property (p_divide) else $error("core strobe too dense"); // [RL1]
endmodule : rcs_reset_clock_startup
`default_nettype wire

// ---- rcs_debug_probe.sv ----
// Purpose: debug probe model on the single-wire line
// Assumes: device outputs settle after the rising edge
// Notes: attaches only while code runs, drops on abort
`timescale 1ns/1ps
`default_nettype none
module rcs_debug_probe (
  input wire logic clk,
  input wire logic sysRst,
  input wire logic debugAbort,
  input wire logic attach,
  input wire logic wantReset,
  output logic sessionActive,
  output logic debugReq
);
  initial sessionActive = 1'b0;
  always @(negedge clk) begin
    if (debugAbort) sessionActive <= 1'b0;
    else if (attach && !sysRst) sessionActive <= 1'b1;
  end
  // a request only means something inside a live session
  assign debugReq = wantReset && sessionActive;
endmodule : rcs_debug_probe
`default_nettype wire

// ---- reset_and_clock_startup_test.sv ----
// Purpose: self-checking bench for reset gathering and start-up clocks
// Assumes: inputs change on the falling edge
// Notes: clkEn is dropped once to show that a request waits out a freeze
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_startup_test;
  import rcs_pkg::*;
  typedef struct packed {rcs_rst_src_t req; logic expRst;} rcs_row_t;
  logic clk = 1'b0, rst = 1'b1, supRise = 1'b0, supFall = 1'b0, memEmpty = 1'b1, swReq = 1'b0;
  logic attach = 1'b0, wantRst = 1'b0, probeReq, session;
  logic clkEnTb = 1'b1;
  rcs_rst_src_t tbReq = '0;
  rcs_clk_src_t swSel = RCS_CLK_FAST_INT;
  rcs_osc_cfg_t cfg = '0;
  logic sysRst, coreClkEn, fIntOn, sIntOn, fExtOn, sExtOn, fGpio, sInGpio, sOutGpio, boot, abort;
  rcs_clk_src_t sel;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  // one source per row, last row idle
  rcs_row_t rows[6] = '{{5'h10, 1'b1}, {5'h08, 1'b1}, {5'h04, 1'b1}, {5'h02, 1'b1}, {5'h01, 1'b1}, {5'h00, 1'b0}};
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  rcs_reset_clock_startup i_rcs_reset_clock_startup (.clk(clk), .rst(rst), .clkEn(clkEnTb),
    .supplyAboveRise(supRise), .supplyAboveFall(supFall),
    .rstReq(rcs_rst_src_t'(tbReq | {3'h0, probeReq, 1'h0})), .progMemEmpty(memEmpty),
    .debugSessionActive(session), .clkSwitchReq(swReq), .clkSwitchSel(swSel), .oscCfg(cfg),
    .sysRst(sysRst), .coreClkEn(coreClkEn), .coreClkSel(sel), .fastIntOscOn(fIntOn),
    .slowIntOscOn(sIntOn), .fastExtOscOn(fExtOn), .slowExtOscOn(sExtOn), .fastOscPinIsGpio(fGpio),
    .slowOscInPinIsGpio(sInGpio), .slowOscOutPinIsGpio(sOutGpio), .bootFromLoader(boot),
    .debugAbort(abort));
  rcs_debug_probe i_rcs_debug_probe (.clk(clk), .sysRst(sysRst), .debugAbort(abort), .attach(attach),
    .wantReset(wantRst), .sessionActive(session), .debugReq(probeReq));
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task automatic chk2(input rcs_clk_src_t got, input rcs_clk_src_t exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk2
  task automatic chk3(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk3
  task automatic waitRst(input logic v);
    for (int i = 0; i < 20 && sysRst !== v; i++) @(negedge clk);
    chk1(sysRst, v);
  endtask : waitRst
  task automatic gap;
    for (int i = 0; i < 20 && coreClkEn !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    n = 1;
    while (coreClkEn !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk3(n, int'(STARTUP_DIV));
  endtask : gap
  task automatic switchTo(input rcs_clk_src_t s);
    swSel = s;
    swReq = 1'b1;
    @(negedge clk);
    swReq = 1'b0;
    repeat (2) @(negedge clk);
  endtask : switchTo
  task automatic settle(input rcs_osc_cfg_t c);
    cfg = c;
    repeat (3) @(negedge clk);
  endtask : settle
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk1(sysRst, 1'b1);
    supRise = 1'b1;
    supFall = 1'b1;
    waitRst(1'b0);
    chk2(sel, RCS_CLK_FAST_INT);
    chk1(boot, 1'b1);
    chk1(fIntOn & sIntOn, 1'b1);
    chk1(fGpio & sInGpio & sOutGpio, 1'b1);
    gap();
    memEmpty = 1'b0;
    foreach (rows[i]) begin
      tbReq = rows[i].req;
      repeat (3) @(negedge clk);
      chk1(sysRst, rows[i].expRst);
      tbReq = '0;
      waitRst(1'b0);
      chk2(sel, RCS_CLK_FAST_INT);
    end
    chk1(boot, 1'b0);
    supFall = 1'b0;
    supRise = 1'b0;
    waitRst(1'b1);
    supFall = 1'b1;
    repeat (8) @(negedge clk);
    chk1(sysRst, 1'b1);
    supRise = 1'b1;
    waitRst(1'b0);
    settle(3'h4);
    chk1(fExtOn, 1'b1);
    chk1(fGpio, 1'b0);
    switchTo(RCS_CLK_FAST_EXT);
    chk2(sel, RCS_CLK_FAST_EXT);
    settle(3'h6);
    chk1(sExtOn, 1'b0);
    switchTo(RCS_CLK_SLOW_EXT);
    chk2(sel, RCS_CLK_FAST_EXT);
    settle(3'h7);
    chk1(sExtOn, 1'b1);
    chk1(sInGpio, 1'b0);
    chk1(sOutGpio, 1'b0);
    switchTo(RCS_CLK_SLOW_EXT);
    chk2(sel, RCS_CLK_SLOW_EXT);
    attach = 1'b1;
    repeat (3) @(negedge clk);
    chk1(session, 1'b1);
    tbReq = 5'h01;
    waitRst(1'b1);
    for (int i = 0; i < 20 && abort !== 1'b1; i++) @(negedge clk);
    chk1(abort, 1'b1);
    tbReq = '0;
    waitRst(1'b0);
    chk2(sel, RCS_CLK_FAST_INT);
    repeat (3) @(negedge clk);
    chk1(session, 1'b1);
    wantRst = 1'b1;
    waitRst(1'b1);
    wantRst = 1'b0;
    waitRst(1'b0);
    // a request raised while frozen must not act until the enable returns
    clkEnTb = 1'b0;
    tbReq = 5'h08;
    repeat (4) @(negedge clk);
    chk1(sysRst, 1'b0);
    clkEnTb = 1'b1;
    waitRst(1'b1);
    tbReq = '0;
    waitRst(1'b0);
    repeat (2) @(negedge clk);
    switchTo(RCS_CLK_SLOW_EXT);
    chk2(sel, RCS_CLK_SLOW_EXT);
    // mid-run reset must bring back the start-up state
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk1(sysRst, 1'b1);
    chk2(sel, RCS_CLK_FAST_INT);
    chk1(fExtOn | sExtOn | abort, 1'b0);
    chk1(fGpio & sInGpio & sOutGpio, 1'b1);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk1(sysRst, 1'b1);
    waitRst(1'b0);
    finish_test();
  end
  initial begin
    #(CLK_PERIOD_NS * 3000);
    fail_count++;
    finish_test();
  end
endmodule : reset_and_clock_startup_test
`default_nettype wire
